/* hcp_regs.vh */
// hcp_regs.vh: constants for the host port pin logic
// assumes inclusion by hcp_host_port.v only; hcp_sync.v does not include it
`ifndef HCP_REGS_VH
`define HCP_REGS_VH
// host interface strap encodings
`define HCP_IF_SPI 1'b0
`define HCP_IF_PAR 1'b1
// bus width strap encodings
`define HCP_WIDTH_16 1'b0
`define HCP_WIDTH_32 1'b1
// parallel access states
`define HCP_ST_IDLE 2'h0
`define HCP_ST_WAIT 2'h1
`define HCP_ST_RDY 2'h2
`define HCP_ST_HIGH 2'h3
// spi frame size in bits
`define HCP_SPI_BITS 6'h20
// reset values
`define HCP_DATA_RST 32'h00000000
`endif

/* hcp_sync.v */
// hcp_sync.v: two flip-flop level synchroniser for pin inputs
// assumes inputs are asynchronous to clk_i
`timescale 1ns/10ps
module hcp_sync #(
    parameter WIDTH = 1
) (
    input wire clk_i,
    input wire rst_b_i,
    input wire [WIDTH-1:0] async_i,
    output reg [WIDTH-1:0] sync_o
);
    reg [WIDTH-1:0] meta_reg;

    // first stage read only by the second stage
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            meta_reg <= {WIDTH{1'b0}};
            sync_o <= {WIDTH{1'b0}};
        end else begin
            meta_reg <= async_i;
            sync_o <= meta_reg;
        end
    end
endmodule

/* hcp_host_port.v */
// hcp_host_port.v: pin level host port, parallel or spi slave
// assumes all pins asynchronous to clk_i; serial clock far slower than clk_i
//
// Overview of operation
// - phase strap 1: sample input on trailing edge, shift output on leading edge
// - byte lanes 0 and 1 enables work in both 16 and 32 bit modes
// - byte lanes 2 and 3 enables only work in 32 bit mode
// - lane enables are active low; only enabled bytes are written
// - in spi mode lane 1 enable pin is the serial data input
// - polarity strap 0 idles clock low, 1 idles high
// - in parallel mode drive ready low once the access may complete
// - drive ready high before releasing it to high impedance
// - pending interrupts drive the interrupt output low
// - inhibit bit 1 forces the interrupt output high
// - phase strap 0: sample on leading edge, shift on trailing edge
`timescale 1ns/10ps
`include "hcp_regs.vh"
module hcp_host_port #(
    parameter DW = 32
) (
    input wire clk_i,
    input wire rst_b_i,
    input wire if_select_strap_i,
    input wire bus_width_strap_i,
    input wire chip_sel_n_i,
    input wire read_write_n_i,
    input wire write_byte_lane0_en_n_i,
    input wire write_byte_lane1_en_n_i,
    input wire write_byte_lane2_en_n_i,
    input wire write_byte_lane3_en_n_i,
    input wire [DW-1:0] host_data_i,
    output reg [DW-1:0] host_data_o,
    output reg [DW-1:0] host_data_oe_o,
    output reg ready_n_o,
    output reg ready_n_oe_o,
    input wire core_ready_i,
    input wire [DW-1:0] core_rd_data_i,
    output reg core_req_o,
    output reg core_wr_o,
    output reg [3:0] core_byte_en_o,
    output reg [DW-1:0] core_wr_data_o,
    input wire [DW-1:0] spi_tx_word_i,
    output reg spi_frame_done_o,
    output reg [DW-1:0] spi_rx_word_o,
    input wire irq_pending_i,
    input wire global_interrupt_inhibit_i,
    output reg irq_n_o
);
    // serial transmit shifter, declared early as the data output block reads it
    reg [DW-1:0] tx_reg;

    // strap meanings of shared pins in spi mode
    wire serial_clock_polarity_strap;
    wire serial_clock_phase_strap;
    assign serial_clock_polarity_strap = write_byte_lane3_en_n_i;
    assign serial_clock_phase_strap = read_write_n_i;

    // pin side inputs, all synchronised
    wire [DW+9:0] pin_async;
    wire [DW+9:0] pin_sync;
    assign pin_async = {host_data_i, if_select_strap_i, bus_width_strap_i, chip_sel_n_i,
        read_write_n_i, write_byte_lane0_en_n_i, write_byte_lane1_en_n_i,
        write_byte_lane2_en_n_i, write_byte_lane3_en_n_i,
        serial_clock_polarity_strap, serial_clock_phase_strap};

    hcp_sync #(.WIDTH(DW+10)) u_sync (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .async_i(pin_async),
        .sync_o(pin_sync)
    );

    wire [DW-1:0] data_s;
    wire is_par;
    wire is_32;
    wire cs_n_s;
    wire rw_n_s;
    wire [3:0] be_n_s;
    wire cpol_s;
    wire cpha_s;
    assign data_s = pin_sync[DW+9:10];
    assign is_par = (pin_sync[9] == `HCP_IF_PAR);
    assign is_32 = (pin_sync[8] == `HCP_WIDTH_32);
    assign cs_n_s = pin_sync[7];
    assign rw_n_s = pin_sync[6];
    assign be_n_s = {pin_sync[2], pin_sync[3], pin_sync[4], pin_sync[5]};
    assign cpol_s = pin_sync[1];
    assign cpha_s = pin_sync[0];

    // serial aliases of the shared lane pins
    wire sclk_s;
    wire mosi_s;
    wire ssel_n_s;
    assign sclk_s = be_n_s[0];
    assign mosi_s = be_n_s[1];
    assign ssel_n_s = be_n_s[2];

    // byte enables: active low pins, upper lanes gated by width
    function [3:0] lane_en;
        input [3:0] be_n;
        input wide;
        begin
            lane_en[1:0] = ~be_n[1:0];
            lane_en[3:2] = wide ? ~be_n[3:2] : 2'h0;
        end
    endfunction

    // parallel access state machine
    reg [1:0] state_reg;
    reg [1:0] state_next;
    always @* begin
        state_next = state_reg;
        case (state_reg)
            `HCP_ST_IDLE: begin
                if (is_par && !cs_n_s) begin
                    state_next = `HCP_ST_WAIT;
                end
            end
            `HCP_ST_WAIT: begin
                if (core_ready_i) begin
                    state_next = `HCP_ST_RDY;
                end
            end
            `HCP_ST_RDY: begin
                // hold ready low until the host lets go of select
                if (cs_n_s) begin
                    state_next = `HCP_ST_HIGH;
                end
            end
            `HCP_ST_HIGH: begin
                state_next = `HCP_ST_IDLE;
            end
            default: begin
                state_next = `HCP_ST_IDLE;
            end
        endcase
    end

    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_reg <= `HCP_ST_IDLE;
            core_req_o <= 1'b0;
            core_wr_o <= 1'b0;
            core_byte_en_o <= 4'h0;
            core_wr_data_o <= `HCP_DATA_RST;
            ready_n_o <= 1'b1;
            ready_n_oe_o <= 1'b0;
        end else begin
            state_reg <= state_next;
            // one cycle request at the start of an access
            core_req_o <= (state_reg == `HCP_ST_IDLE) && (state_next == `HCP_ST_WAIT);
            if (state_reg == `HCP_ST_IDLE) begin
                core_wr_o <= ~rw_n_s;
                core_byte_en_o <= rw_n_s ? 4'h0 : lane_en(be_n_s, is_32);
                core_wr_data_o <= is_32 ? data_s : {{(DW-16){1'b0}}, data_s[15:0]};
            end
            // ready low while complete, driven high one cycle, then released
            ready_n_o <= (state_next != `HCP_ST_RDY);
            ready_n_oe_o <= (state_next == `HCP_ST_RDY) || (state_next == `HCP_ST_HIGH);
        end
    end

    // read data onto the parallel bus while access is ready
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            host_data_o <= `HCP_DATA_RST;
            host_data_oe_o <= {DW{1'b0}};
        end else if (is_par) begin
            if (state_reg == `HCP_ST_WAIT && core_ready_i) begin
                host_data_o <= core_rd_data_i;
            end
            if (state_next == `HCP_ST_RDY && rw_n_s && !cs_n_s) begin
                host_data_oe_o <= is_32 ? {DW{1'b1}} : {{(DW-16){1'b0}}, 16'hFFFF};
            end else begin
                host_data_oe_o <= {DW{1'b0}};
            end
        end else begin
            // bit 0 doubles as serial output; undriven while unselected
            host_data_o <= {host_data_o[DW-1:1], tx_reg[DW-1]};
            host_data_oe_o <= {{(DW-1){1'b0}}, ~ssel_n_s};
        end
    end

    // serial clock edge detect on the synchronised copy
    reg sclk_d_reg;
    wire sclk_rise;
    wire sclk_fall;
    wire lead_edge;
    wire trail_edge;
    assign sclk_rise = sclk_s && !sclk_d_reg;
    assign sclk_fall = !sclk_s && sclk_d_reg;
    assign lead_edge = cpol_s ? sclk_fall : sclk_rise;
    assign trail_edge = cpol_s ? sclk_rise : sclk_fall;

    wire sample_edge;
    wire shift_edge;
    assign sample_edge = cpha_s ? trail_edge : lead_edge;
    assign shift_edge = cpha_s ? lead_edge : trail_edge;

    reg [DW-1:0] rx_reg;
    reg [5:0] bit_cnt_reg;
    reg first_reg;
    wire spi_act;
    assign spi_act = !is_par && !ssel_n_s;

    // serial shifter; frame restarts whenever select goes high
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sclk_d_reg <= 1'b0;
            rx_reg <= `HCP_DATA_RST;
            tx_reg <= `HCP_DATA_RST;
            bit_cnt_reg <= 6'h00;
            first_reg <= 1'b1;
            spi_frame_done_o <= 1'b0;
            spi_rx_word_o <= `HCP_DATA_RST;
        end else begin
            sclk_d_reg <= sclk_s;
            spi_frame_done_o <= 1'b0;
            if (!spi_act) begin
                bit_cnt_reg <= 6'h00;
                first_reg <= 1'b1;
                tx_reg <= spi_tx_word_i;
            end else begin
                if (sample_edge) begin
                    rx_reg <= {rx_reg[DW-2:0], mosi_s};
                    if (bit_cnt_reg == `HCP_SPI_BITS - 6'h01) begin
                        bit_cnt_reg <= 6'h00;
                        spi_frame_done_o <= 1'b1;
                        spi_rx_word_o <= {rx_reg[DW-2:0], mosi_s};
                    end else begin
                        bit_cnt_reg <= bit_cnt_reg + 6'h01;
                    end
                end
                // with phase 1 the first leading edge presents the msb tx_reg[DW-1], no shift
                if (shift_edge) begin
                    if (first_reg && cpha_s) begin
                        first_reg <= 1'b0;
                    end else begin
                        tx_reg <= {tx_reg[DW-2:0], 1'b0};
                    end
                end
            end
        end
    end

    // interrupt pin, inhibit overrides pending requests
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            irq_n_o <= 1'b1;
        end else begin
            irq_n_o <= global_interrupt_inhibit_i ? 1'b1 : ~irq_pending_i;
        end
    end
endmodule

/* hcp_hp_asserts.sv */
// checker for the host port pins: ready handshake, lane enables, interrupt, serial output
// assumes it is bound to hcp_host_port and that straps only move while reset is low
`timescale 1ns/10ps
module hcp_hp_chk #(
    parameter DW = 32
) (
    input wire clk_i,
    input wire rst_b_i,
    input wire if_select_strap_i,
    input wire bus_width_strap_i,
    input wire write_byte_lane0_en_n_i,
    input wire write_byte_lane1_en_n_i,
    input wire write_byte_lane2_en_n_i,
    input wire [DW-1:0] host_data_oe_o,
    input wire ready_n_o,
    input wire ready_n_oe_o,
    input wire core_ready_i,
    input wire core_req_o,
    input wire core_wr_o,
    input wire [3:0] core_byte_en_o,
    input wire irq_pending_i,
    input wire global_interrupt_inhibit_i,
    input wire irq_n_o
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);
    // grant from the core while ready is still high, then ready driven low
    sequence s_grant;
        $rose(core_ready_i) && ready_n_o;
    endsequence
    sequence s_ready_low;
        !ready_n_o && ready_n_oe_o;
    endsequence
    property p_rdy_ans;
        s_grant |-> ##[1:2] s_ready_low;
    endproperty
    a_rdy_ans: assert property (p_rdy_ans) else $error("ready not low after grant");
    property p_rdy_drv;
        !ready_n_o |-> ready_n_oe_o;
    endproperty
    a_rdy_drv: assert property (p_rdy_drv) else $error("ready low while not driven");
    // the pull-up alone is too slow, so the pin must be driven high first
    property p_rdy_rel;
        $fell(ready_n_oe_o) |-> $past(ready_n_o);
    endproperty
    a_rdy_rel: assert property (p_rdy_rel) else $error("ready released while low");
    property p_irq_pend;
        irq_pending_i && !global_interrupt_inhibit_i |=> !irq_n_o;
    endproperty
    a_irq_pend: assert property (p_irq_pend) else $error("pending irq not signalled");
    property p_irq_inh;
        global_interrupt_inhibit_i |=> irq_n_o;
    endproperty
    a_irq_inh: assert property (p_irq_inh) else $error("irq output low while inhibited");
    property p_be16;
        core_req_o && core_wr_o && !bus_width_strap_i |-> core_byte_en_o[3:2] == 2'h0;
    endproperty
    a_be16: assert property (p_be16) else $error("upper lanes enabled in 16-bit mode");
    property p_be_lo;
        core_req_o && core_wr_o && if_select_strap_i |->
            core_byte_en_o[1:0] == ~{write_byte_lane1_en_n_i, write_byte_lane0_en_n_i};
    endproperty
    a_be_lo: assert property (p_be_lo) else $error("low lane enables wrong");
    property p_miso_z;
        !if_select_strap_i && write_byte_lane2_en_n_i [*5] |-> !host_data_oe_o[0];
    endproperty
    a_miso_z: assert property (p_miso_z) else $error("serial output driven while deselected");
endmodule
bind hcp_host_port hcp_hp_chk #(.DW(DW)) u_chk (.*);

/* hcp_host_model.sv */
// host processor model driving the port pins, parallel or serial
// assumes the bench calls its tasks and sets the mode straps
`timescale 1ns/10ps
module hcp_host_model (
    input wire clk_i,
    input wire ready_pin_i,
    input wire [31:0] bus_i,
    output reg cs_n_o,
    output reg rw_n_o,
    output reg [3:0] ln_n_o,
    output reg [31:0] wdata_o
);
    initial begin
        cs_n_o = 1'b1;
        rw_n_o = 1'b1;
        ln_n_o = 4'hF;
        wdata_o = 32'h0;
    end
    // one access; select held low until the ready pin goes low
    task par(input logic wr, input logic [3:0] be_n, input logic [31:0] d, output logic [31:0] rd);
        integer n;
        begin
            @(negedge clk_i);
            rw_n_o = !wr;
            ln_n_o = be_n;
            wdata_o = d;
            cs_n_o = 1'b0;
            n = 0;
            while (ready_pin_i !== 1'b0 && n < 50) begin
                @(negedge clk_i);
                n = n + 1;
            end
            rd = bus_i;
            @(negedge clk_i);
            cs_n_o = 1'b1;
            wdata_o = ~d; // released bus shows no stale value
        end
    endtask
    // one 32-bit frame, clock still outside it, 8 clk cycles per serial clock
    task spi(input logic ph, input logic pol, input logic [31:0] mo, output logic [31:0] mi);
        integer i;
        begin
            @(negedge clk_i);
            rw_n_o = ph;
            ln_n_o[3] = pol;
            ln_n_o[0] = pol;
            if (!ph) ln_n_o[1] = mo[31];
            repeat (4) @(negedge clk_i);
            ln_n_o[2] = 1'b0;
            repeat (4) @(negedge clk_i);
            for (i = 31; i >= 0; i = i - 1) begin
                ln_n_o[0] = !pol;
                if (ph) ln_n_o[1] = mo[i];
                else mi[i] = bus_i[0];
                repeat (4) @(negedge clk_i);
                ln_n_o[0] = pol;
                if (ph) mi[i] = bus_i[0];
                else if (i > 0) ln_n_o[1] = mo[i-1];
                repeat (4) @(negedge clk_i);
            end
            ln_n_o[2] = 1'b1;
            ln_n_o[1] = !ln_n_o[1];
        end
    endtask
endmodule

/* tb_top.sv */
// bench for the host port pins in parallel and serial modes
// assumes the host model drives the pins and the bench plays the core side
`timescale 1ns/10ps
module tb_top;
    reg clk_i = 1'b0, rst_b_i = 1'b0, if_sel = 1'b1, width = 1'b1, core_ready_i = 1'b0, irq_p = 1'b0, inh = 1'b0;
    reg [31:0] rd_data = 32'h5A6B7C8D, tx_word = 32'h0, mi, got_wd;
    reg [3:0] got_be;
    wire cs_n, rw_n, req, wr, done, irq_n, rdy, rdy_oe;
    wire [3:0] ln_n, be;
    wire [31:0] hd_o, hd_oe, wdat, wd, rx, bus;
    integer error_cnt = 0, n_tests = 0, cyc = 0, wt = 0, nd = 0, k;
    // each bus bit is driven by whichever side enables it
    assign bus = (hd_oe & hd_o) | (~hd_oe & wdat);
    initial forever #20 clk_i = ~clk_i;
    hcp_host_model host (.clk_i(clk_i), .ready_pin_i(rdy_oe ? rdy : 1'b1), .bus_i(bus), .cs_n_o(cs_n),
        .rw_n_o(rw_n), .ln_n_o(ln_n), .wdata_o(wdat));
    hcp_host_port #(.DW(32)) DUT (.clk_i(clk_i), .rst_b_i(rst_b_i), .if_select_strap_i(if_sel),
        .bus_width_strap_i(width), .chip_sel_n_i(cs_n), .read_write_n_i(rw_n),
        .write_byte_lane0_en_n_i(ln_n[0]), .write_byte_lane1_en_n_i(ln_n[1]),
        .write_byte_lane2_en_n_i(ln_n[2]), .write_byte_lane3_en_n_i(ln_n[3]), .host_data_i(bus),
        .host_data_o(hd_o), .host_data_oe_o(hd_oe), .ready_n_o(rdy), .ready_n_oe_o(rdy_oe),
        .core_ready_i(core_ready_i), .core_rd_data_i(rd_data), .core_req_o(req), .core_wr_o(wr),
        .core_byte_en_o(be), .core_wr_data_o(wd), .spi_tx_word_i(tx_word), .spi_frame_done_o(done),
        .spi_rx_word_o(rx), .irq_pending_i(irq_p), .global_interrupt_inhibit_i(inh), .irq_n_o(irq_n));
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        begin
            n_tests = n_tests + 1;
            if (seen !== exp) begin
                error_cnt = error_cnt + 1;
                $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    task conclude;
        begin
            if (error_cnt == 0 && n_tests > 0) $display("ALL TESTS PASSED");
            else $display("TESTS FAILED");
            $finish;
        end
    endtask
    // parallel access plus idle time so ready can be driven high and released
    task acc(input logic w, input logic [3:0] b);
        begin
            host.par(w, b, 32'hA1B2C3D4, mi);
            repeat (6) @(negedge clk_i);
            chk({31'h0, rdy_oe}, 32'h0);
        end
    endtask
    // core side grants three cycles after a request, withdraws once ready is low; hang guard
    always @(negedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc > 5000) begin
            error_cnt = error_cnt + 1;
            conclude;
        end else begin
            if (done) nd <= nd + 1;
            if (req) got_be <= be;
            if (req) got_wd <= wd;
            wt <= req ? 3 : (wt > 0 ? wt - 1 : 0);
            core_ready_i <= (wt == 1) ? 1'b1 : ((rdy_oe && !rdy) ? 1'b0 : core_ready_i);
        end
    end
    initial begin
        repeat (5) @(negedge clk_i);
        rst_b_i = 1'b1;
        repeat (4) @(negedge clk_i);
        for (k = 0; k < 32; k = k + 1) begin
            width = k[4];
            acc(1'b1, k[3:0]);
            chk(got_be, k[4] ? {28'h0, ~k[3:0]} : {30'h0, ~k[1:0]});
            chk(got_wd, k[4] ? 32'hA1B2C3D4 : 32'h0000C3D4);
        end
        acc(1'b0, 4'hF);
        chk(mi, 32'h5A6B7C8D);
        for (k = 0; k < 4; k = k + 1) begin
            irq_p = k[0];
            inh = k[1];
            repeat (2) @(negedge clk_i);
            chk({31'h0, irq_n}, {31'h0, !(k[0] && !k[1])});
        end
        rst_b_i = 1'b0;
        if_sel = 1'b0;
        repeat (5) @(negedge clk_i);
        rst_b_i = 1'b1;
        repeat (4) @(negedge clk_i);
        for (k = 0; k < 4; k = k + 1) begin
            tx_word = 32'hC3A50F96 ^ k;
            host.spi(k[0], k[1], 32'h9D3C5AE1 + k, mi);
            repeat (6) @(negedge clk_i);
            chk(rx, 32'h9D3C5AE1 + k);
            chk(mi, tx_word);
            chk(nd, k + 1);
            chk({31'h0, hd_oe[0]}, 32'h0);
        end
        conclude;
    end
endmodule
